// ==== rtl/gfx_pkg.sv ====
package gfx_pkg;
	localparam logic [15:0] IDX_PORT  = 16'h03ce;
	localparam logic [15:0] DATA_PORT = 16'h03cf;

	localparam logic [3:0] IX_FILL_COLOUR         = 4'h0;
	localparam logic [3:0] IX_FILL_PLANE_ENABLE   = 4'h1;
	localparam logic [3:0] IX_REFERENCE_COLOUR    = 4'h2;
	localparam logic [3:0] IX_ROTATE_AND_FUNCTION = 4'h3;
	localparam logic [3:0] IX_READ_PLANE_SELECT   = 4'h4;
	localparam logic [3:0] IX_GRAPHICS_MODE       = 4'h5;
	localparam logic [3:0] IX_MISC_GRAPHICS       = 4'h6;
	localparam logic [3:0] IX_COMPARE_IGNORE      = 4'h7;
	localparam logic [3:0] IX_PIXEL_WRITE_MASK    = 4'h8;
	localparam logic [3:0] NUM_CFG                = 4'h9;

	localparam logic [7:0] IDX_MASK = 8'h0f;
	localparam logic [7:0] CFG_MASK [9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03,
		8'h7b, 8'h0f, 8'h0f, 8'hff};
	localparam logic [7:0] CFG_RST [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'hff};

	localparam int GM_READ_MODE = 3;
	localparam int GM_ODD_EVEN  = 4;
	localparam int MISC_CHAIN   = 1;
	localparam int CHAIN_BIT    = 16;

	localparam logic [1:0] WM_LATCH = 2'h1;
	localparam logic [1:0] WM_COLOUR = 2'h2;
	localparam logic [1:0] WM_FILL  = 2'h3;

	localparam logic [19:0] WIN_A0 = 20'ha0000;
	localparam logic [19:0] WIN_AF = 20'haffff;
	localparam logic [19:0] WIN_B0 = 20'hb0000;
	localparam logic [19:0] WIN_B7 = 20'hb7fff;
	localparam logic [19:0] WIN_B8 = 20'hb8000;
	localparam logic [19:0] WIN_BF = 20'hbffff;

	localparam logic [7:0] MISS_DATA = 8'hff;
	localparam int FIFO_W = 32;
	localparam int FIFO_D = 8;

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_ISSUE = 5'h02,
		S_WAIT  = 5'h04,
		S_LATCH = 5'h08,
		S_DONE  = 5'h10
	} state_t;
endpackage

// ==== rtl/stream_if.sv ====
interface stream_if #(parameter int W = 32) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/gfx_fifo.sv ====
module gfx_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	input wire logic clk_i,     // System clock
	input wire logic reset_n_i, // Synchronous reset, active low
	stream_if.snk    wr,        // Filling side
	stream_if.src    rd         // Draining side
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic          room_reg;
	logic          push;
	logic          pop;
	logic [AW:0]   cnt_next;

	assign push     = wr.valid & room_reg;
	assign pop      = rd.ready & (cnt_reg != '0);
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign wr.ready = room_reg;
	assign rd.valid = cnt_reg != '0;
	assign rd.data  = mem[rp_reg];

	always_ff @(posedge clk_i) begin
		if (push)
			mem[wp_reg] <= wr.data;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wp_reg   <= '0;
			rp_reg   <= '0;
			cnt_reg  <= '0;
			room_reg <= 1'b1;
		end else begin
			if (push)
				wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
			if (pop)
				rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
			cnt_reg  <= cnt_next;
			// Registered so the ready seen outside comes from a flop
			room_reg <= cnt_next != (AW+1)'(D);
		end
	end
endmodule

// ==== rtl/planar_graphics_datapath.sv ====
// Summary of operation
// - Write mode 2 writes low four data bits as colour to masked pixels.
// - Every host memory read that hits the window loads all four plane bytes into the latches.
// - Function 00 passes data, 01 ANDs, 10 ORs, 11 XORs with latches.
// - Index register low four bits pick the register; upper bits read zero.
// - Write mode 2 ignores fill colour and enables but applies function.
// - Write mode 3 masks with rotated data ANDed with write mask; fill colour.
// - Write mode 3 mask 0 keeps latched pixel, 1 takes fill colour.
// - Mode bit 3 picks read mode: one plane byte or colour compare.
// - Compare read gives 1 per matching pixel; word reads compare both bytes.
// - Mode bit 4 set sends even addresses to planes 0,2, odd to 1,3.
// - Pattern 00 shifts each plane msb first onto its own video bit.
// - Pattern 01 emits two-bit pixels, plane 0 then 1, plane 2 then 3.
// - Pattern 1x emits four-bit pixels, nibbles of planes 0 to 3.
// - In pattern 00 without per-character reload, each shifter feeds the next lower one.
// - Chain bit replaces address bit 0 and uses it to pick planes.
// - Memory map field selects which host window hits display memory.
// - Compare-ignore bits drop reference bits at 0; compare read only.
// - Write mask 0 keeps latched bit in all planes, 1 lets data through.
module planar_graphics_datapath (
	input  wire logic        clk_sys_i,     // 25 MHz system clock
	input  wire logic        reset_n_i,     // Synchronous reset, active low
	input  wire logic        io_wr_i,       // I/O write strobe
	input  wire logic        io_rd_i,       // I/O read strobe
	input  wire logic [15:0] io_addr_i,     // I/O port address
	input  wire logic [7:0]  io_wdata_i,    // I/O write data
	output logic      [7:0]  io_rdata_o,    // I/O read data
	input  wire logic        mem_rd_i,      // Host memory read request
	input  wire logic        mem_wr_i,      // Host memory write request
	input  wire logic        mem_word_i,    // 16-bit access
	input  wire logic [19:0] mem_addr_i,    // Host byte address
	input  wire logic [15:0] mem_wdata_i,   // Host write data
	output logic      [15:0] mem_rdata_o,   // Host read data
	output logic             mem_ack_o,     // Access finished pulse
	output logic      [15:0] plane_addr_o,  // Plane memory address
	output logic             plane_rd_o,    // Plane read pulse
	output logic      [3:0]  plane_we_o,    // Per-plane write pulse
	output logic      [31:0] plane_wdata_o, // Plane write data
	input  wire logic [31:0] plane_rdata_i, // Plane read data
	input  wire logic [31:0] vid_data_i,    // Fetched plane word
	input  wire logic        vid_valid_i,   // Fetched word valid
	output logic             vid_ready_o,   // FIFO can take a word
	input  wire logic        shift_load_i,  // Shifter load pulse
	input  wire logic        dot_en_i,      // Pixel clock enable
	input  wire logic        shift_chain_i, // Shifters not reloaded per character
	output logic      [3:0]  video_o        // Serial pixel bits
);
	logic [7:0] idx_reg;
	logic [7:0] cfg_reg [9];
	logic [7:0] fill_colour;
	logic [7:0] fill_plane_enable;
	logic [7:0] reference_colour;
	logic [7:0] rotate_and_function;
	logic [7:0] read_plane_select;
	logic [7:0] graphics_mode_control;
	logic [7:0] misc_graphics_config;
	logic [7:0] compare_ignore_mask;
	logic [7:0] pixel_write_mask;

	assign fill_colour           = cfg_reg[gfx_pkg::IX_FILL_COLOUR];
	assign fill_plane_enable     = cfg_reg[gfx_pkg::IX_FILL_PLANE_ENABLE];
	assign reference_colour      = cfg_reg[gfx_pkg::IX_REFERENCE_COLOUR];
	assign rotate_and_function   = cfg_reg[gfx_pkg::IX_ROTATE_AND_FUNCTION];
	assign read_plane_select     = cfg_reg[gfx_pkg::IX_READ_PLANE_SELECT];
	assign graphics_mode_control = cfg_reg[gfx_pkg::IX_GRAPHICS_MODE];
	assign misc_graphics_config  = cfg_reg[gfx_pkg::IX_MISC_GRAPHICS];
	assign compare_ignore_mask   = cfg_reg[gfx_pkg::IX_COMPARE_IGNORE];
	assign pixel_write_mask      = cfg_reg[gfx_pkg::IX_PIXEL_WRITE_MASK];

	logic io_idx;
	logic io_dat;
	logic idx_ok;
	assign io_idx = io_addr_i == gfx_pkg::IDX_PORT;
	assign io_dat = io_addr_i == gfx_pkg::DATA_PORT;
	assign idx_ok = idx_reg[3:0] < gfx_pkg::NUM_CFG;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			idx_reg <= '0;
		else if (io_wr_i && io_idx)
			idx_reg <= io_wdata_i & gfx_pkg::IDX_MASK;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 9; i++)
				cfg_reg[i] <= gfx_pkg::CFG_RST[i];
		end else if (io_wr_i && io_dat && idx_ok) begin
			cfg_reg[idx_reg[3:0]] <= io_wdata_i & gfx_pkg::CFG_MASK[idx_reg[3:0]];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			io_rdata_o <= '0;
		else if (io_rd_i && io_idx)
			io_rdata_o <= idx_reg;
		else if (io_rd_i && io_dat && idx_ok)
			io_rdata_o <= cfg_reg[idx_reg[3:0]];
		else if (io_rd_i)
			io_rdata_o <= '0;
	end

	// Host access sequencing; a word access runs as two byte passes
	gfx_pkg::state_t state_reg;
	logic        is_wr_reg;
	logic        word_reg;
	logic        hi_reg;
	logic [19:0] addr_reg;
	logic [15:0] data_reg;
	logic [3:0][7:0] lat_reg;
	logic [19:0] cur_addr;
	logic        hit;
	logic [16:0] off;
	logic [15:0] paddr;
	logic        split;
	logic [3:0]  we_mask;
	logic [7:0]  wb;
	logic        last;

	assign cur_addr = addr_reg + {19'h0, hi_reg};
	assign wb       = hi_reg ? data_reg[15:8] : data_reg[7:0];
	assign last     = !word_reg || hi_reg;

	always_comb begin
		hit = 1'b0;
		off = '0;
		case (misc_graphics_config[3:2])
			2'b00: begin
				hit = cur_addr >= gfx_pkg::WIN_A0 && cur_addr <= gfx_pkg::WIN_BF;
				off = 17'(cur_addr - gfx_pkg::WIN_A0);
			end
			2'b01: begin
				hit = cur_addr >= gfx_pkg::WIN_A0 && cur_addr <= gfx_pkg::WIN_AF;
				off = 17'(cur_addr - gfx_pkg::WIN_A0);
			end
			2'b10: begin
				hit = cur_addr >= gfx_pkg::WIN_B0 && cur_addr <= gfx_pkg::WIN_B7;
				off = 17'(cur_addr - gfx_pkg::WIN_B0);
			end
			default: begin
				hit = cur_addr >= gfx_pkg::WIN_B8 && cur_addr <= gfx_pkg::WIN_BF;
				off = 17'(cur_addr - gfx_pkg::WIN_B8);
			end
		endcase
	end

	// Chained mode: bit 0 comes from a higher offset bit, original bit 0 picks planes
	assign paddr = misc_graphics_config[gfx_pkg::MISC_CHAIN] ?
		{off[15:1], off[gfx_pkg::CHAIN_BIT]} : off[15:0];
	assign split = graphics_mode_control[gfx_pkg::GM_ODD_EVEN] |
		misc_graphics_config[gfx_pkg::MISC_CHAIN];
	assign we_mask = !split ? 4'hf : (cur_addr[0] ? 4'ha : 4'h5);

	// Write datapath
	logic [1:0]  wmode;
	logic [1:0]  func;
	logic [15:0] rot2;
	logic [7:0]  rot;
	logic [7:0]  pmask;
	logic [3:0][7:0] wdata;
	assign wmode = graphics_mode_control[1:0];
	assign func  = rotate_and_function[4:3];
	assign rot2  = {wb, wb} >> rotate_and_function[2:0];
	assign rot   = rot2[7:0];
	assign pmask = (wmode == gfx_pkg::WM_FILL) ? (rot & pixel_write_mask) :
		pixel_write_mask;

	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_plane
			logic [7:0] src;
			logic [7:0] alu;
			logic [7:0] val;
			always_comb begin
				case (wmode)
					2'b00: src = fill_plane_enable[p] ? {8{fill_colour[p]}} : rot;
					gfx_pkg::WM_COLOUR: src = {8{wb[p]}};
					default: src = rot;
				endcase
				case (func)
					2'b01: alu = src & lat_reg[p];
					2'b10: alu = src | lat_reg[p];
					2'b11: alu = src ^ lat_reg[p];
					default: alu = src;
				endcase
				case (wmode)
					gfx_pkg::WM_LATCH: val = lat_reg[p];
					gfx_pkg::WM_FILL: val = {8{fill_colour[p]}};
					default: val = alu;
				endcase
			end
			assign wdata[p] = (val & pmask) | (lat_reg[p] & ~pmask);
		end
	endgenerate

	// Read datapath
	logic [7:0] cmp;
	logic [1:0] rsel;
	logic [7:0] rbyte;
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_cmp
			assign cmp[b] = ~|(({plane_rdata_i[24+b], plane_rdata_i[16+b],
				plane_rdata_i[8+b], plane_rdata_i[b]} ^ reference_colour[3:0]) &
				compare_ignore_mask[3:0]);
		end
	endgenerate
	assign rsel  = split ? {read_plane_select[1], cur_addr[0]} : read_plane_select[1:0];
	assign rbyte = graphics_mode_control[gfx_pkg::GM_READ_MODE] ? cmp :
		plane_rdata_i[rsel*8 +: 8];

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_reg <= gfx_pkg::S_IDLE;
			is_wr_reg <= 1'b0;
			word_reg  <= 1'b0;
			hi_reg    <= 1'b0;
			addr_reg  <= '0;
			data_reg  <= '0;
		end else begin
			case (state_reg)
				gfx_pkg::S_IDLE: if (mem_rd_i || mem_wr_i) begin
					is_wr_reg <= mem_wr_i;
					word_reg  <= mem_word_i;
					hi_reg    <= 1'b0;
					addr_reg  <= mem_addr_i;
					data_reg  <= mem_wdata_i;
					state_reg <= gfx_pkg::S_ISSUE;
				end
				gfx_pkg::S_ISSUE: begin
					if (hit && !is_wr_reg)
						state_reg <= gfx_pkg::S_WAIT;
					else if (last)
						state_reg <= gfx_pkg::S_DONE;
					else
						hi_reg <= 1'b1;
				end
				gfx_pkg::S_WAIT: state_reg <= gfx_pkg::S_LATCH;
				gfx_pkg::S_LATCH: begin
					if (last) begin
						state_reg <= gfx_pkg::S_DONE;
					end else begin
						hi_reg    <= 1'b1;
						state_reg <= gfx_pkg::S_ISSUE;
					end
				end
				gfx_pkg::S_DONE: state_reg <= gfx_pkg::S_IDLE;
				default: state_reg <= gfx_pkg::S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			lat_reg <= '0;
		else if (state_reg == gfx_pkg::S_LATCH)
			lat_reg <= plane_rdata_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			plane_addr_o  <= '0;
			plane_rd_o    <= 1'b0;
			plane_we_o    <= '0;
			plane_wdata_o <= '0;
		end else begin
			plane_rd_o <= 1'b0;
			plane_we_o <= '0;
			if (state_reg == gfx_pkg::S_ISSUE && hit) begin
				plane_addr_o <= paddr;
				if (is_wr_reg) begin
					plane_we_o    <= we_mask;
					plane_wdata_o <= wdata;
				end else begin
					plane_rd_o <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			mem_rdata_o <= '0;
			mem_ack_o   <= 1'b0;
		end else begin
			mem_ack_o <= state_reg == gfx_pkg::S_DONE;
			if (state_reg == gfx_pkg::S_IDLE && mem_rd_i)
				mem_rdata_o <= '0;
			else if ((state_reg == gfx_pkg::S_ISSUE && !hit && !is_wr_reg) ||
				state_reg == gfx_pkg::S_LATCH) begin
				if (hi_reg)
					mem_rdata_o[15:8] <= hit ? rbyte : gfx_pkg::MISS_DATA;
				else
					mem_rdata_o[7:0] <= hit ? rbyte : gfx_pkg::MISS_DATA;
			end
		end
	end

	// Video serialiser fed through the plane-word FIFO
	stream_if #(.W(gfx_pkg::FIFO_W)) vin ();
	stream_if #(.W(gfx_pkg::FIFO_W)) vout ();
	assign vin.valid   = vid_valid_i;
	assign vin.data    = vid_data_i;
	assign vid_ready_o = vin.ready;
	assign vout.ready  = shift_load_i;

	gfx_fifo #(.W(gfx_pkg::FIFO_W), .D(gfx_pkg::FIFO_D)) u_fifo (
		.clk_i     (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr        (vin),
		.rd        (vout)
	);

	logic [3:0][7:0] sr_reg;
	logic [3:0][7:0] sh1;
	logic [3:0][7:0] sh2;
	logic [3:0][7:0] sh4;
	logic [1:0]      pat;
	assign pat = graphics_mode_control[6:5];

	genvar s;
	generate
		for (s = 0; s < 4; s++) begin : g_shift
			if (s < 3) begin : g_link
				assign sh1[s] = {sr_reg[s][6:0], shift_chain_i & sr_reg[s+1][7]};
			end else begin : g_top
				assign sh1[s] = {sr_reg[s][6:0], 1'b0};
			end
		end
	endgenerate
	assign sh2 = {{sr_reg[3][5:0], 2'b00}, {sr_reg[2][5:0], sr_reg[3][7:6]},
		{sr_reg[1][5:0], 2'b00}, {sr_reg[0][5:0], sr_reg[1][7:6]}};
	assign sh4 = {{sr_reg[3][3:0], 4'h0}, {sr_reg[2][3:0], sr_reg[3][7:4]},
		{sr_reg[1][3:0], sr_reg[2][7:4]}, {sr_reg[0][3:0], sr_reg[1][7:4]}};

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			sr_reg <= '0;
		end else if (shift_load_i) begin
			// An empty FIFO at load time blanks the character rather than stalling
			sr_reg <= vout.valid ? vout.data : '0;
		end else if (dot_en_i) begin
			case (pat)
				2'b00: sr_reg <= sh1;
				2'b01: sr_reg <= sh2;
				default: sr_reg <= sh4;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			video_o <= '0;
		end else if (dot_en_i && !shift_load_i) begin
			case (pat)
				2'b00: video_o <= {sr_reg[3][7], sr_reg[2][7], sr_reg[1][7],
					sr_reg[0][7]};
				2'b01: video_o <= {sr_reg[2][7:6], sr_reg[0][7:6]};
				default: video_o <= sr_reg[0][7:4];
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	logic issue_wr;
	assign issue_wr = state_reg == gfx_pkg::S_ISSUE && hit && is_wr_reg;

	chk_index_zero: assert property (io_wr_i && io_idx |=> idx_reg[7:4] == 4'h0)
		else $error("index upper bits not zero");
	chk_latch_load: assert property (state_reg == gfx_pkg::S_LATCH |=>
		lat_reg == $past(plane_rdata_i))
		else $error("latches not loaded on read");
	chk_mode2_colour: assert property (issue_wr && wmode == gfx_pkg::WM_COLOUR && func == 2'b00
		|=> plane_wdata_o[7:0] == (({8{$past(wb[0])}} & $past(pixel_write_mask)) |
		($past(lat_reg[0]) & ~$past(pixel_write_mask))))
		else $error("mode 2 colour write wrong");
	chk_mode3_fill: assert property (issue_wr && wmode == gfx_pkg::WM_FILL |=>
		plane_wdata_o[15:8] == (({8{$past(fill_colour[1])}} & $past(pmask)) |
		($past(lat_reg[1]) & ~$past(pmask))))
		else $error("mode 3 fill write wrong");
	chk_mask_keep: assert property (issue_wr |=> ((plane_wdata_o ^ $past(lat_reg)) &
		~{4{$past(pixel_write_mask)}}) == 32'h0)
		else $error("masked bit not from latch");
	chk_oddeven_we: assert property (issue_wr && graphics_mode_control[gfx_pkg::GM_ODD_EVEN]
		|=> plane_we_o == ($past(cur_addr[0]) ? 4'ha : 4'h5))
		else $error("odd/even plane steering wrong");
	chk_chain_addr: assert property (state_reg == gfx_pkg::S_ISSUE && hit &&
		misc_graphics_config[gfx_pkg::MISC_CHAIN] |=> plane_addr_o[0] == $past(off[16]))
		else $error("chained address bit wrong");
	chk_window_miss: assert property (state_reg == gfx_pkg::S_ISSUE && !hit |=>
		plane_we_o == 4'h0 && !plane_rd_o)
		else $error("access outside window reached planes");
	chk_ack_bound: assert property (state_reg == gfx_pkg::S_IDLE && (mem_rd_i || mem_wr_i)
		|-> ##[3:8] mem_ack_o)
		else $error("host access not acknowledged in time");
	chk_plain_shift: assert property (dot_en_i && !shift_load_i && pat == 2'b00 |=>
		video_o == {$past(sr_reg[3][7]), $past(sr_reg[2][7]), $past(sr_reg[1][7]),
		$past(sr_reg[0][7])})
		else $error("plain shift output wrong");

	cov_mode3_write: cover property (issue_wr && wmode == gfx_pkg::WM_FILL);
	cov_compare_read: cover property (state_reg == gfx_pkg::S_LATCH &&
		graphics_mode_control[gfx_pkg::GM_READ_MODE]);
	cov_word_read: cover property (state_reg == gfx_pkg::S_LATCH && hi_reg);
	cov_chained_shift: cover property (dot_en_i && shift_chain_i && pat == 2'b00);
endmodule

// ==== test/plane_mem_model.sv ====
module plane_mem_model (
	input  wire logic        clk_i,   // System clock
	input  wire logic [15:0] addr_i,  // Plane address
	input  wire logic        rd_i,    // Read pulse
	input  wire logic [3:0]  we_i,    // Per-plane write pulse
	input  wire logic [31:0] wdata_i, // Write data, plane p in byte p
	output logic      [31:0] rdata_o  // Read data, the cycle after rd_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [65536];
	initial begin
		rdata_o = 32'h0;
		foreach (mem[a]) mem[a] = 32'h0;
	end
	// Outside the answer cycle the bus flips, so stale data never passes for valid
	always @(posedge clk_i) begin
		rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
		for (int p = 0; p < 4; p++) begin
			if (we_i[p]) mem[addr_i][8*p +: 8] <= wdata_i[8*p +: 8];
		end
	end
endmodule

// ==== test/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i, reset_n_i, io_wr_i, io_rd_i, mem_rd_i, mem_wr_i, mem_word_i;
	logic        vid_valid_i, shift_load_i, dot_en_i, shift_chain_i, mem_ack_o, vid_ready_o;
	logic        plane_rd_o;
	logic [15:0] io_addr_i, mem_wdata_i, mem_rdata_o, plane_addr_o, q;
	logic [7:0]  io_wdata_i, io_rdata_o, b;
	logic [19:0] mem_addr_i;
	logic [31:0] plane_wdata_o, plane_rdata_i, vid_data_i;
	logic [3:0]  plane_we_o, video_o;
	int          err_count, n_checks;
	logic [31:0] lat_w = 32'h0f3355a5;
	logic [31:0] hi_w = 32'hc3817e18;
	logic [19:0] win [3] = '{20'ha0010, 20'hb0010, 20'hb8010};
	logic [3:0]  hit [3] = '{4'b0011, 4'b0101, 4'b1001};

	always #20 clk_sys_i = ~clk_sys_i;

	planar_graphics_datapath planar_graphics_datapath_inst (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
		.io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i), .mem_word_i(mem_word_i),
		.mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o),
		.mem_ack_o(mem_ack_o), .plane_addr_o(plane_addr_o), .plane_rd_o(plane_rd_o),
		.plane_we_o(plane_we_o), .plane_wdata_o(plane_wdata_o), .plane_rdata_i(plane_rdata_i),
		.vid_data_i(vid_data_i), .vid_valid_i(vid_valid_i), .vid_ready_o(vid_ready_o),
		.shift_load_i(shift_load_i), .dot_en_i(dot_en_i), .shift_chain_i(shift_chain_i),
		.video_o(video_o));

	plane_mem_model plane_mem_model_inst (.clk_i(clk_sys_i), .addr_i(plane_addr_o),
		.rd_i(plane_rd_o), .we_i(plane_we_o), .wdata_i(plane_wdata_o), .rdata_o(plane_rdata_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		io_wr_i = 1'b1;
		io_addr_i = a;
		io_wdata_i = d;
		@(posedge clk_sys_i);
		#1;
		io_wr_i = 1'b0;
	endtask

	task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		io_rd_i = 1'b1;
		io_addr_i = a;
		@(posedge clk_sys_i);
		#1;
		io_rd_i = 1'b0;
		d = io_rdata_o;
	endtask

	task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
		io_wr(gfx_pkg::IDX_PORT, {4'h0, i});
		io_wr(gfx_pkg::DATA_PORT, d);
	endtask

	task automatic reg_rd(input logic [3:0] i, output logic [7:0] d);
		io_wr(gfx_pkg::IDX_PORT, {4'h0, i});
		io_rd(gfx_pkg::DATA_PORT, d);
	endtask

	// Requests are pulsed once; the design drops any made while busy
	task automatic mem_op(input logic wr, input logic wd16, input logic [19:0] a,
		input logic [15:0] d, output logic [15:0] r);
		int n;
		@(posedge clk_sys_i);
		#1;
		{mem_wr_i, mem_rd_i, mem_word_i, mem_addr_i, mem_wdata_i} = {wr, ~wr, wd16, a, d};
		@(posedge clk_sys_i);
		#1;
		{mem_wr_i, mem_rd_i} = 2'h0;
		for (n = 0; n < 20 && mem_ack_o !== 1'b1; n++) begin
			@(posedge clk_sys_i);
			#1;
		end
		if (n == 20) begin
			err_count++;
			close_out();
		end
		r = mem_rdata_o;
	endtask

	task automatic show(input logic [31:0] w, input logic [1:0] pat, input int n, input logic ch);
		logic [3:0] m;
		@(posedge clk_sys_i);
		#1;
		shift_chain_i = ch;
		shift_load_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		shift_load_i = 1'b0;
		dot_en_i = 1'b1;
		for (int k = 0; k < n; k++) begin
			@(posedge clk_sys_i);
			#1;
			m = (k > 7) ? 4'h7 : 4'hf;
			chk(32'(video_o & m), 32'(vexp(w, pat, k) & m));
		end
		dot_en_i = 1'b0;
	endtask

	// Past eight dots only chained pattern 00 is defined; the top shifter's fill is not
	function automatic logic [3:0] vexp(input logic [31:0] w, input logic [1:0] pat, input int k);
		logic [3:0] r;
		for (int i = 0; i < 4; i++) begin
			if (pat == 2'h0) r[i] = (k < 8) ? w[8*i + 7 - k] : w[8*i + 23 - k];
			else if (pat == 2'h1) r[i] = w[8*(i/2*2 + k/4) + 6 - 2*(k%4) + i%2];
			else r[i] = w[8*(k/2) + 4 - 4*(k%2) + i];
		end
		return r;
	endfunction

	function automatic logic [7:0] cmp(input logic [31:0] w, input logic [3:0] c,
		input logic [3:0] m);
		logic [7:0] r;
		for (int j = 0; j < 8; j++) r[j] = &(~({w[24+j], w[16+j], w[8+j], w[j]} ^ c) | ~m);
		return r;
	endfunction

	function automatic logic [31:0] wexp(input logic [31:0] d, input logic [1:0] f,
		input logic [7:0] k);
		logic [31:0] o;
		o = (f == 2'h0) ? d : (f == 2'h1) ? d & lat_w : (f == 2'h2) ? d | lat_w : d ^ lat_w;
		return (o & {4{k}}) | (lat_w & ~{4{k}});
	endfunction

	function automatic logic [31:0] spread(input logic [3:0] c);
		return {{8{c[3]}}, {8{c[2]}}, {8{c[1]}}, {8{c[0]}}};
	endfunction

	function automatic logic [31:0] wd(input int i);
		return 32'h96a53c0f ^ (32'(i) * 32'h01230567);
	endfunction

	initial begin
		{clk_sys_i, reset_n_i, io_wr_i, io_rd_i, mem_rd_i, mem_wr_i, mem_word_i} = '0;
		{vid_valid_i, shift_load_i, dot_en_i, shift_chain_i} = '0;
		{io_addr_i, io_wdata_i, mem_addr_i, mem_wdata_i, vid_data_i} = '0;
		err_count = 0;
		n_checks = 0;
		repeat (8) @(posedge clk_sys_i);
		#1;
		reset_n_i = 1'b1;
		chk(32'({mem_ack_o, plane_we_o, video_o, plane_rd_o}), 32'h0);
		plane_mem_model_inst.mem[16'h0010] = lat_w;
		plane_mem_model_inst.mem[16'h0011] = hi_w;
		plane_mem_model_inst.mem[16'h8010] = lat_w;
		for (int i = 0; i < 9; i++) begin
			reg_rd(4'(i), b);
			chk(32'(b), 32'(gfx_pkg::CFG_RST[i]));
			reg_wr(4'(i), 8'hff);
			reg_rd(4'(i), b);
			chk(32'(b), 32'(gfx_pkg::CFG_MASK[i]));
			reg_wr(4'(i), gfx_pkg::CFG_RST[i]);
		end
		reg_rd(4'h9, b);
		chk(32'(b), 32'h0);
		io_wr(gfx_pkg::IDX_PORT, 8'hf3);
		io_rd(gfx_pkg::IDX_PORT, b);
		chk(32'(b), 32'h3);
		for (int p = 0; p < 4; p++) begin
			reg_wr(4'h4, 8'(p));
			mem_op(1'b0, 1'b0, 20'ha0010, 16'h0, q);
			chk(32'(q[7:0]), 32'(lat_w[8*p +: 8]));
		end
		reg_wr(4'h5, 8'h08);
		for (int i = 0; i < 5; i++) begin
			reg_wr(4'h2, 8'(i * 5));
			reg_wr(4'h7, 8'(4'hf >> i));
			mem_op(1'b0, 1'b1, 20'ha0010, 16'h0, q);
			chk(32'(q), 32'({cmp(hi_w, 4'(i * 5), 4'hf >> i), cmp(lat_w, 4'(i * 5), 4'hf >> i)}));
		end
		reg_wr(4'h5, 8'h00);
		mem_op(1'b0, 1'b0, 20'ha0010, 16'h0, q);
		reg_wr(4'h8, 8'h3c);
		reg_wr(4'h0, 8'h0f);
		reg_wr(4'h1, 8'h0f);
		reg_wr(4'h5, 8'h02);
		for (int f = 0; f < 4; f++) begin
			reg_wr(4'h3, 8'(f << 3));
			mem_op(1'b1, 1'b0, 20'ha0020 + 20'(f), 16'h0006, q);
			chk(plane_mem_model_inst.mem[16'h20 + 16'(f)], wexp(spread(4'h6), 2'(f), 8'h3c));
		end
		reg_wr(4'h3, 8'h02);
		reg_wr(4'h0, 8'h09);
		reg_wr(4'h8, 8'hf0);
		reg_wr(4'h5, 8'h03);
		mem_op(1'b1, 1'b0, 20'ha0030, 16'h00b4, q);
		chk(plane_mem_model_inst.mem[16'h30], wexp(spread(4'h9), 2'h0, 8'h20));
		reg_wr(4'h3, 8'h00);
		reg_wr(4'h8, 8'hff);
		reg_wr(4'h1, 8'h00);
		reg_wr(4'h5, 8'h10);
		mem_op(1'b1, 1'b0, 20'ha0041, 16'h0077, q);
		chk(plane_mem_model_inst.mem[16'h41], 32'h77007700);
		reg_wr(4'h5, 8'h00);
		reg_wr(4'h6, 8'h02);
		mem_op(1'b1, 1'b0, 20'hb0040, 16'h0066, q);
		chk(plane_mem_model_inst.mem[16'h41], 32'h77667766);
		reg_wr(4'h4, 8'h00);
		for (int m = 0; m < 4; m++) begin
			reg_wr(4'h6, 8'(m << 2));
			for (int a = 0; a < 3; a++) begin
				mem_op(1'b0, 1'b0, win[a], 16'h0, q);
				chk(32'(q[7:0]), hit[a][m] ? 32'(lat_w[7:0]) : 32'hff);
			end
		end
		reg_wr(4'h6, 8'h00);
		chk(32'(vid_ready_o), 32'h1);
		vid_valid_i = 1'b1;
		for (int i = 0; i < 8; i++) begin
			vid_data_i = wd(i);
			@(posedge clk_sys_i);
			#1;
		end
		vid_valid_i = 1'b0;
		chk(32'(vid_ready_o), 32'h0);
		for (int p = 0; p < 4; p++) begin
			reg_wr(4'h5, 8'(p << 5));
			show(wd(p), 2'(p), 8, 1'b0);
		end
		reg_wr(4'h5, 8'h00);
		show(wd(4), 2'h0, 16, 1'b1);
		chk(32'(vid_ready_o), 32'h1);
		for (int i = 5; i < 9; i++) show((i < 8) ? wd(i) : 32'h0, 2'h0, 8, 1'b0);
		close_out();
	end
endmodule
